// >>> verilog/rtcs_defs.svh
// Offsets, field positions, reset values and counts of the dual slow counter.
// Assumes a 32-bit register port with byte addresses on an 8-bit address.
`ifndef RTCS_DEFS_SVH
`define RTCS_DEFS_SVH
// Register byte offsets
`define RTCS_A_CTRL 8'h00
`define RTCS_A_FIX_CNT 8'h04
`define RTCS_A_FIX_ALARM 8'h08
`define RTCS_A_FIX_TRIM 8'h0C
`define RTCS_A_FLX_CNT 8'h10
`define RTCS_A_FLX_ALARM 8'h14
`define RTCS_A_FLX_AFRAC 8'h18
`define RTCS_A_FLX_TRIM 8'h1C
`define RTCS_A_STB_TGT 8'h20
`define RTCS_A_STB_PER 8'h24
`define RTCS_A_CAP_CNT 8'h28
`define RTCS_A_CAP_FRAC 8'h2C
`define RTCS_A_STAT 8'h30
`define RTCS_A_IRQ_EN 8'h34
`define RTCS_A_IRQ_CLR 8'h38
`define RTCS_A_OSC 8'h3C
// Control fields
`define RTCS_C_FIX_EN 0
`define RTCS_C_FLX_EN 1
`define RTCS_C_SRC_RC 2
`define RTCS_C_SHIFT_LO 4
`define RTCS_C_STB_EN 8
`define RTCS_C_CAP_EN 9
`define RTCS_C_CAP_FALL 10
`define RTCS_C_FRC_OFF 12
`define RTCS_C_SRC_OFF 13
`define RTCS_C_XTAL_OFF 14
`define RTCS_CTRL_RST 32'h0000_0000
// Trim fields
`define RTCS_T_VAL_LO 0
`define RTCS_T_EXP_LO 8
`define RTCS_T_EN 15
`define RTCS_TRIM_W 4
// Status bits
`define RTCS_S_FIX_ALM 0
`define RTCS_S_FLX_ALM 1
`define RTCS_S_FLX_PER 2
`define RTCS_S_STROBE 3
`define RTCS_S_CAPTURE 4
`define RTCS_IRQ_W 5
`define RTCS_WAKE_MASK 5'h11
// Counts
`define RTCS_FIX_SHIFT 4'hF
`define RTCS_PERIOD_UNITS 6'h3C
`define RTCS_FRAC_W 15
`endif

// >>> verilog/rtcs_pkg.sv
// Types shared by the dual slow counter block.
// Assumes nothing beyond the defines header for numbers.
package rtcs_pkg;
  // One register port access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rtcs_bus_req_t;
  // Strobe output state
  typedef enum logic [1:0] {
    STB_IDLE = 2'b01,
    STB_PULSE = 2'b10
  } rtcs_stb_state_t;
endpackage

// >>> verilog/rtcs_prescaler.sv
// Power-of-two prescaler counting slow source edges.
// Assumes src_edge is a one-cycle pulse per source period in sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "rtcs_defs.svh"
module rtcs_prescaler (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Source and setting
  input wire logic src_edge,
  input wire logic clear,
  input wire logic [3:0] shift,
  // Results
  output logic [`RTCS_FRAC_W-1:0] frac,
  output logic tick
);
  logic [15:0] full; // Divide mask, 2^N - 1
  logic [`RTCS_FRAC_W-1:0] mask;
  logic [`RTCS_FRAC_W-1:0] frac_reg;

  assign full = (16'h0001 << shift) - 16'h0001;
  assign mask = full[`RTCS_FRAC_W-1:0];
  // Greater-or-equal recovers if the setting shrinks mid-count
  assign tick = src_edge && (frac_reg >= mask);
  assign frac = frac_reg;

  // Source-cycle phase within one prescaled unit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frac_reg <= '0;
    end else if (ce) begin
      if (clear) begin
        frac_reg <= '0;
      end else if (src_edge) begin
        frac_reg <= tick ? '0 : frac_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/rtcs_counter.sv
// Loadable count with periodic signed trim.
// Assumes tick is a one-cycle pulse per prescaled unit.
`timescale 1ns/100ps
`default_nettype none
`include "rtcs_defs.svh"
module rtcs_counter #(
  parameter int W = 32
) (
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Count inputs
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Trim setting
  input wire logic trim_en,
  input wire logic [`RTCS_TRIM_W-1:0] trim_val,
  input wire logic [3:0] trim_exp,
  // Result
  output logic [W-1:0] count
);
  logic [15:0] ivl_reg; // Ticks since last trim
  logic ivl_last;
  logic [W-1:0] count_reg;
  logic [W-1:0] step; // One plus signed trim

  assign ivl_last = ivl_reg >= ((16'h0001 << trim_exp) - 16'h0001);
  assign step = {{(W-`RTCS_TRIM_W){trim_val[`RTCS_TRIM_W-1]}}, trim_val} + W'(1);
  assign count = count_reg;

  // Trim interval counter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ivl_reg <= '0;
    end else if (ce) begin
      if (load) begin
        ivl_reg <= '0;
      end else if (tick) begin
        ivl_reg <= ivl_last ? '0 : ivl_reg + 16'h0001;
      end
    end
  end

  // Count, corrected once per interval
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (ce) begin
      if (load) begin
        count_reg <= load_val;
      end else if (tick && trim_en && ivl_last) begin
        count_reg <= count_reg + step;
      end else if (tick) begin
        count_reg <= count_reg + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/rtcs_top.sv
// Dual slow real-time counter: fixed seconds count and flexible count
// with alarms, periodic alarm, sensor trigger pulse and input capture.
// Assumes slow oscillator levels and the event pin are synchronous to
// sys_clk, which runs far faster than the 32 kHz sources.
`timescale 1ns/100ps
`default_nettype none
`include "rtcs_defs.svh"

module rtcs_top #(
  parameter int CW = 32
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire rtcs_pkg::rtcs_bus_req_t bus,
  output logic [31:0] rdata,
  // Slow oscillator levels
  input wire logic slow_crystal_oscillator_in,
  input wire logic slow_rc_oscillator_in,
  // Power status
  input wire logic buck_active,
  // Oscillator enables
  output logic fast_rc_oscillator_en,
  output logic slow_rc_oscillator_en,
  output logic slow_crystal_oscillator_en,
  // Sensor pins
  input wire logic capture_event_in,
  output logic sensor_trigger_pulse,
  // System
  output logic irq,
  output logic wake
);
  import rtcs_pkg::*;

  // Register file
  logic [31:0] ctrl_reg; // Control
  logic [CW-1:0] fix_alarm_reg; // Fixed alarm, seconds
  logic [15:0] fix_trim_reg; // Fixed trim
  logic [CW-1:0] flx_alarm_reg; // Flexible alarm units
  logic [`RTCS_FRAC_W-1:0] flx_afrac_reg; // Alarm source cycle
  logic [15:0] flx_trim_reg; // Flexible trim
  logic [CW-1:0] stb_tgt_reg; // Trigger target
  logic [CW-1:0] stb_per_reg; // Trigger reload step
  logic [CW-1:0] cap_cnt_reg; // Captured units
  logic [`RTCS_FRAC_W-1:0] cap_frac_reg; // Captured cycle
  logic [`RTCS_IRQ_W-1:0] stat_reg; // Sticky events
  logic [`RTCS_IRQ_W-1:0] irq_en_reg; // Interrupt enables
  logic [31:0] rdata_reg;

  // Source edge detection
  logic xtal_q; // Previous crystal level
  logic rc_q; // Previous RC level
  logic cap_q; // Previous event pin level
  logic xtal_edge;
  logic rc_edge;
  logic flx_edge;

  // Counter datapath
  logic fix_tick;
  logic flx_tick;
  logic [CW-1:0] fix_cnt;
  logic [CW-1:0] flx_cnt;
  logic [`RTCS_FRAC_W-1:0] fix_frac;
  logic [`RTCS_FRAC_W-1:0] flx_frac;
  logic fix_load;
  logic flx_load;

  // Event detection
  logic fix_hit;
  logic fix_hit_q;
  logic flx_hit;
  logic flx_hit_q;
  logic stb_hit;
  logic stb_hit_q;
  logic [5:0] per_reg; // Units within period
  logic fix_ev;
  logic flx_ev;
  logic per_ev;
  logic stb_ev;
  logic cap_ev;
  logic [`RTCS_IRQ_W-1:0] ev;
  logic [`RTCS_IRQ_W-1:0] clr;

  // Outputs from flops
  rtcs_stb_state_t stb_state_reg;
  logic irq_reg;
  logic wake_reg;
  logic frc_en_reg;
  logic src_en_reg;
  logic xtal_en_reg;

  // Register write decode
  function automatic logic wr_at(input logic [7:0] a);
    wr_at = bus.wr && (bus.addr == a);
  endfunction

  // Sample previous source and pin levels
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      xtal_q <= 1'b0;
      rc_q <= 1'b0;
      cap_q <= 1'b0;
    end else if (ce) begin
      xtal_q <= slow_crystal_oscillator_in;
      rc_q <= slow_rc_oscillator_in;
      cap_q <= capture_event_in;
    end
  end

  assign xtal_edge = slow_crystal_oscillator_in && !xtal_q;
  assign rc_edge = slow_rc_oscillator_in && !rc_q;
  // Flexible source follows the slow clock selector
  assign flx_edge = ctrl_reg[`RTCS_C_SRC_RC] ? rc_edge : xtal_edge;

  // Control register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= `RTCS_CTRL_RST;
    end else if (ce && wr_at(`RTCS_A_CTRL)) begin
      ctrl_reg <= bus.wdata;
    end
  end

  // Alarm and trim settings
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fix_alarm_reg <= '0;
      fix_trim_reg <= '0;
      flx_alarm_reg <= '0;
      flx_afrac_reg <= '0;
      flx_trim_reg <= '0;
      stb_per_reg <= '0;
    end else if (ce) begin
      if (wr_at(`RTCS_A_FIX_ALARM)) begin
        fix_alarm_reg <= bus.wdata[CW-1:0];
      end
      if (wr_at(`RTCS_A_FIX_TRIM)) begin
        fix_trim_reg <= bus.wdata[15:0];
      end
      if (wr_at(`RTCS_A_FLX_ALARM)) begin
        flx_alarm_reg <= bus.wdata[CW-1:0];
      end
      if (wr_at(`RTCS_A_FLX_AFRAC)) begin
        flx_afrac_reg <= bus.wdata[`RTCS_FRAC_W-1:0];
      end
      if (wr_at(`RTCS_A_FLX_TRIM)) begin
        flx_trim_reg <= bus.wdata[15:0];
      end
      if (wr_at(`RTCS_A_STB_PER)) begin
        stb_per_reg <= bus.wdata[CW-1:0];
      end
    end
  end

  assign fix_load = ce && wr_at(`RTCS_A_FIX_CNT);
  assign flx_load = ce && wr_at(`RTCS_A_FLX_CNT);

  // Fixed counter: crystal only, divide by 2^15 to seconds
  rtcs_prescaler u_fix_pre (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .src_edge(xtal_edge && ctrl_reg[`RTCS_C_FIX_EN]),
    .clear(fix_load),
    .shift(`RTCS_FIX_SHIFT),
    .frac(fix_frac),
    .tick(fix_tick)
  );

  // Seconds count, kept running regardless of power mode
  rtcs_counter #(.W(CW)) u_fix_cnt (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(fix_tick),
    .load(fix_load),
    .load_val(bus.wdata[CW-1:0]),
    .trim_en(fix_trim_reg[`RTCS_T_EN]),
    .trim_val(fix_trim_reg[`RTCS_T_VAL_LO +: `RTCS_TRIM_W]),
    .trim_exp(fix_trim_reg[`RTCS_T_EXP_LO +: 4]),
    .count(fix_cnt)
  );

  // Flexible counter: selectable 2^N prescale
  rtcs_prescaler u_flx_pre (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .src_edge(flx_edge && ctrl_reg[`RTCS_C_FLX_EN]),
    .clear(flx_load),
    .shift(ctrl_reg[`RTCS_C_SHIFT_LO +: 4]),
    .frac(flx_frac),
    .tick(flx_tick)
  );

  // Flexible count in prescaled units
  rtcs_counter #(.W(CW)) u_flx_cnt (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(flx_tick),
    .load(flx_load),
    .load_val(bus.wdata[CW-1:0]),
    .trim_en(flx_trim_reg[`RTCS_T_EN]),
    .trim_val(flx_trim_reg[`RTCS_T_VAL_LO +: `RTCS_TRIM_W]),
    .trim_exp(flx_trim_reg[`RTCS_T_EXP_LO +: 4]),
    .count(flx_cnt)
  );

  // Match terms; an event is the first cycle of equality
  assign fix_hit = ctrl_reg[`RTCS_C_FIX_EN] && (fix_cnt == fix_alarm_reg);
  assign flx_hit = ctrl_reg[`RTCS_C_FLX_EN] && (flx_cnt == flx_alarm_reg)
                   && (flx_frac == flx_afrac_reg);
  assign stb_hit = ctrl_reg[`RTCS_C_STB_EN] && ctrl_reg[`RTCS_C_FLX_EN]
                   && (flx_cnt == stb_tgt_reg);

  // Match history for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fix_hit_q <= 1'b0;
      flx_hit_q <= 1'b0;
      stb_hit_q <= 1'b0;
    end else if (ce) begin
      fix_hit_q <= fix_hit;
      flx_hit_q <= flx_hit;
      stb_hit_q <= stb_hit;
    end
  end

  // Absolute alarms fire once per match; count moves back only on a load or a negative-step trim
  assign fix_ev = fix_hit && !fix_hit_q;
  assign flx_ev = flx_hit && !flx_hit_q;
  assign stb_ev = stb_hit && !stb_hit_q;

  // Periodic alarm every 60 prescaled units
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      per_reg <= '0;
    end else if (ce) begin
      if (flx_load) begin
        per_reg <= '0;
      end else if (flx_tick) begin
        per_reg <= (per_reg == `RTCS_PERIOD_UNITS - 6'h01) ? '0 : per_reg + 6'h01;
      end
    end
  end

  assign per_ev = flx_tick && (per_reg == `RTCS_PERIOD_UNITS - 6'h01);

  // Trigger target; reloads by step so no software is needed per pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stb_tgt_reg <= '0;
    end else if (ce) begin
      if (wr_at(`RTCS_A_STB_TGT)) begin
        stb_tgt_reg <= bus.wdata[CW-1:0];
      end else if (stb_ev && (stb_per_reg != '0)) begin
        stb_tgt_reg <= stb_tgt_reg + stb_per_reg;
      end
    end
  end

  // Trigger pulse lasts until next source edge; no power mode gates it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stb_state_reg <= STB_IDLE;
    end else if (ce) begin
      unique case (stb_state_reg)
        STB_IDLE: begin
          if (stb_ev) begin
            stb_state_reg <= STB_PULSE;
          end
        end
        STB_PULSE: begin
          if (flx_edge) begin
            stb_state_reg <= STB_IDLE;
          end
        end
        default: begin
          stb_state_reg <= STB_IDLE;
        end
      endcase
    end
  end

  // Event pin transition, edge chosen by control
  assign cap_ev = ctrl_reg[`RTCS_C_CAP_EN] && (ctrl_reg[`RTCS_C_CAP_FALL]
                  ? (cap_q && !capture_event_in)
                  : (!cap_q && capture_event_in));

  // Snapshot of units and source-cycle phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cap_cnt_reg <= '0;
      cap_frac_reg <= '0;
    end else if (ce && cap_ev) begin
      cap_cnt_reg <= flx_cnt;
      cap_frac_reg <= flx_frac;
    end
  end

  // Sticky status; a new event wins over a clear
  assign ev = {cap_ev, stb_ev, per_ev, flx_ev, fix_ev};
  assign clr = wr_at(`RTCS_A_IRQ_CLR) ? bus.wdata[`RTCS_IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      stat_reg <= '0;
    end else if (ce) begin
      stat_reg <= (stat_reg & ~clr) | ev;
    end
  end

  // Interrupt enables
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_en_reg <= '0;
    end else if (ce && wr_at(`RTCS_A_IRQ_EN)) begin
      irq_en_reg <= bus.wdata[`RTCS_IRQ_W-1:0];
    end
  end

  // Interrupt and wake levels; capture and fixed alarm can wake
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= |(stat_reg & irq_en_reg);
      wake_reg <= |(stat_reg & irq_en_reg & `RTCS_WAKE_MASK);
    end
  end

  // Oscillator enables; slow RC off is ignored, fast RC off is held off while buck_active, crystal off is always obeyed
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frc_en_reg <= 1'b1;
      src_en_reg <= 1'b1;
      xtal_en_reg <= 1'b1;
    end else if (ce) begin
      frc_en_reg <= !ctrl_reg[`RTCS_C_FRC_OFF] || buck_active;
      src_en_reg <= 1'b1;
      xtal_en_reg <= !ctrl_reg[`RTCS_C_XTAL_OFF];
    end
  end

  // Read data, one cycle after the strobe, zero elsewhere
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= '0;
      if (bus.rd) begin
        unique case (bus.addr)
          `RTCS_A_CTRL: rdata_reg <= ctrl_reg;
          `RTCS_A_FIX_CNT: rdata_reg <= 32'(fix_cnt);
          `RTCS_A_FIX_ALARM: rdata_reg <= 32'(fix_alarm_reg);
          `RTCS_A_FIX_TRIM: rdata_reg <= 32'(fix_trim_reg);
          `RTCS_A_FLX_CNT: rdata_reg <= 32'(flx_cnt);
          `RTCS_A_FLX_ALARM: rdata_reg <= 32'(flx_alarm_reg);
          `RTCS_A_FLX_AFRAC: rdata_reg <= 32'(flx_afrac_reg);
          `RTCS_A_FLX_TRIM: rdata_reg <= 32'(flx_trim_reg);
          `RTCS_A_STB_TGT: rdata_reg <= 32'(stb_tgt_reg);
          `RTCS_A_STB_PER: rdata_reg <= 32'(stb_per_reg);
          `RTCS_A_CAP_CNT: rdata_reg <= 32'(cap_cnt_reg);
          `RTCS_A_CAP_FRAC: rdata_reg <= 32'(cap_frac_reg);
          `RTCS_A_STAT: rdata_reg <= 32'(stat_reg);
          `RTCS_A_IRQ_EN: rdata_reg <= 32'(irq_en_reg);
          `RTCS_A_OSC: rdata_reg <= {29'h0, xtal_en_reg, src_en_reg, frc_en_reg};
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  // Output drive
  assign rdata = rdata_reg;
  assign irq = irq_reg;
  assign wake = wake_reg;
  // One-hot code: the pulse state bit is the pin, straight from its flop
  assign sensor_trigger_pulse = stb_state_reg[1];
  assign fast_rc_oscillator_en = frc_en_reg;
  assign slow_rc_oscillator_en = src_en_reg;
  assign slow_crystal_oscillator_en = xtal_en_reg;
endmodule
`default_nettype wire

// >>> tb/rtcs_properties.sv
// Port checker for the dual slow counter top.
// Assumes ce stays high; shadows CTRL and IRQ_EN from bus writes.
`timescale 1ns/100ps
`default_nettype none
`include "rtcs_defs.svh"
module rtcs_properties #(
  parameter int CW = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire rtcs_pkg::rtcs_bus_req_t bus,
  input wire logic [31:0] rdata,
  // Oscillators and power
  input wire logic slow_crystal_oscillator_in,
  input wire logic slow_rc_oscillator_in,
  input wire logic buck_active,
  input wire logic fast_rc_oscillator_en,
  input wire logic slow_rc_oscillator_en,
  input wire logic slow_crystal_oscillator_en,
  // Sensor and system
  input wire logic capture_event_in,
  input wire logic sensor_trigger_pulse,
  input wire logic irq,
  input wire logic wake
);
  import rtcs_pkg::*;
  logic [31:0] ctrl_reg; // Shadow control
  logic [4:0] en_reg; // Shadow enables
  // Shadows follow software writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= 32'h0000_0000;
      en_reg <= 5'h00;
    end else if (ce && bus.wr && bus.addr == `RTCS_A_CTRL) begin
      ctrl_reg <= bus.wdata;
    end else if (ce && bus.wr && bus.addr == `RTCS_A_IRQ_EN) begin
      en_reg <= bus.wdata[4:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_slow_rc; slow_rc_oscillator_en; endproperty
  a_slow_rc: assert property (p_slow_rc) else $error("slow rc enable low");
  // Two stable cycles, since the enable is registered
  property p_fast_rc;
    $stable(ctrl_reg[12]) && $stable(buck_active) && $past(buck_active, 2) == buck_active
      && $past(ctrl_reg[12], 2) == ctrl_reg[12]
      |-> fast_rc_oscillator_en == (!ctrl_reg[12] || buck_active);
  endproperty
  a_fast_rc: assert property (p_fast_rc) else $error("fast rc enable wrong");
  property p_xtal;
    $stable(ctrl_reg[14]) && $past(ctrl_reg[14], 2) == ctrl_reg[14]
      |-> slow_crystal_oscillator_en == !ctrl_reg[14];
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal enable wrong");
  property p_masked;
    bus.wr && bus.addr == `RTCS_A_IRQ_EN && bus.wdata[4:0] == 5'h00 |-> ##2 !irq;
  endproperty
  a_masked: assert property (p_masked) else $error("irq while all masked");
  property p_rd_zero;
    !bus.rd || bus.addr == `RTCS_A_IRQ_CLR || bus.addr > `RTCS_A_OSC |=> rdata == 32'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
  property p_cap;
    ctrl_reg[9] && !ctrl_reg[10] && en_reg[4] && $rose(capture_event_in)
      |-> ##[1:3] (irq && wake);
  endproperty
  a_cap: assert property (p_cap) else $error("capture did not wake");
  property p_stb_en; $rose(sensor_trigger_pulse) |-> $past(ctrl_reg[8]); endproperty
  a_stb_en: assert property (p_stb_en) else $error("pulse while disabled");
  property p_stb_irq; $rose(sensor_trigger_pulse) && en_reg[3] |-> ##[1:2] irq; endproperty
  a_stb_irq: assert property (p_stb_irq) else $error("pulse without irq");
  property p_wake; wake |-> irq; endproperty
  a_wake: assert property (p_wake) else $error("wake without irq");
  // Main scenarios reached
  c_wake: cover property (wake);
  c_stb: cover property ($rose(sensor_trigger_pulse));
  c_buck: cover property (buck_active && ctrl_reg[12]);
endmodule
`default_nettype wire

// >>> tb/rtcs_sensor_model.sv
// External sensor: answers each trigger pulse by flipping its event line.
// Assumes the trigger is synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module rtcs_sensor_model #(
  parameter int DELAY = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Pins
  input wire logic trigger,
  output logic event_out
);
  logic trig_q = 1'b0; // Last trigger level
  int wait_cnt = 0; // Cycles left to answer
  initial event_out = 1'b0;
  // Measurement takes DELAY cycles, then the event edge
  always @(posedge clk) begin
    trig_q <= trigger;
    if (!rst_n) begin
      wait_cnt <= 0;
    end else if (trigger && !trig_q) begin
      wait_cnt <= DELAY;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end
    if (rst_n && wait_cnt == 1) begin
      event_out <= !event_out;
    end
  end
endmodule
`default_nettype wire

// >>> tb/rtcs_top_tb.sv
// Bench for the dual slow counter: register rows, then timed cases.
// Assumes crystal of 8 and RC of 4 sys cycles, made here.
`timescale 1ns/100ps
`default_nettype none
`include "rtcs_defs.svh"
module rtcs_top_tb;
  import rtcs_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } rtcs_row_t;
  localparam int CW = 32;
  logic sys_clk, rst_n, ce, xtal, rc, buck, xtal_run, fast_en, rc_en, xtal_en;
  logic cap_in, pulse, irq, wake;
  logic [31:0] rdata;
  logic [3:0] ph;
  rtcs_bus_req_t bus;
  int miscompares = 0;
  int check_count = 0;
  // Write, read back, expected
  rtcs_row_t rows [9] = '{
    '{`RTCS_A_CTRL, 32'h0000_0000, 32'h0000_0000},
    '{`RTCS_A_FIX_ALARM, 32'h1234_5678, 32'h1234_5678},
    '{`RTCS_A_FLX_ALARM, 32'h0000_00A5, 32'h0000_00A5},
    '{`RTCS_A_FLX_AFRAC, 32'hFFFF_FFFF, 32'h0000_7FFF},
    '{`RTCS_A_STB_PER, 32'h0000_003C, 32'h0000_003C},
    '{`RTCS_A_IRQ_CLR, 32'h0000_001F, 32'h0000_0000},
    '{`RTCS_A_CAP_CNT, 32'h0000_0055, 32'h0000_0000},
    '{8'h40, 32'h0000_0055, 32'h0000_0000},
    '{`RTCS_A_OSC, 32'h0000_0000, 32'h0000_0007}};
  int ns [4] = '{0, 1, 3, 15};
  rtcs_top #(.CW(CW)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .bus(bus),
    .rdata(rdata), .slow_crystal_oscillator_in(xtal), .slow_rc_oscillator_in(rc),
    .buck_active(buck), .fast_rc_oscillator_en(fast_en), .slow_rc_oscillator_en(rc_en),
    .slow_crystal_oscillator_en(xtal_en), .capture_event_in(cap_in),
    .sensor_trigger_pulse(pulse), .irq(irq), .wake(wake));
  rtcs_sensor_model sens_u (.clk(sys_clk), .rst_n(rst_n), .trigger(pulse), .event_out(cap_in));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Slow sources; crystal can be halted
  always @(posedge sys_clk) begin
    ph <= ph + 4'h1;
    rc <= ph[1];
    if (xtal_run) begin
      xtal <= ph[2];
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus <= '0;
    @(posedge sys_clk);
  endtask
  // Data stands in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk);
    bus <= '0;
    @(posedge sys_clk);
    d = rdata;
  endtask
  task automatic edges(input int n);
    repeat (n * 8) @(posedge sys_clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    logic [31:0] v;
    logic [31:0] w;
    int k;
    rst_n = 1'b0;
    ce = 1'b1;
    bus = '0;
    buck = 1'b0;
    xtal = 1'b0;
    rc = 1'b0;
    ph = 4'h0;
    xtal_run = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk({26'h0, irq, wake, pulse, fast_en, rc_en, xtal_en}, 32'h0000_0007);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, v);
      chk(v, rows[i].e);
    end
    $display("test rows done");
    // Off requests; fast RC held by buck
    buck <= 1'b1;
    wr(`RTCS_A_CTRL, 32'h0000_7000);
    repeat (3) @(posedge sys_clk);
    chk({29'h0, fast_en, rc_en, xtal_en}, 32'h0000_0006);
    buck <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rd(`RTCS_A_OSC, v);
    chk(v, 32'h0000_0002);
    $display("test oscillators done");
    foreach (ns[i]) begin
      wr(`RTCS_A_CTRL, 32'h0000_0002 | (32'(ns[i]) << 4));
      wr(`RTCS_A_FLX_CNT, 32'h0000_0000);
      edges(32);
      rd(`RTCS_A_FLX_CNT, v);
      w = 32'h0000_0020 >> ns[i];
      chk({31'h0, v + 32'h1 >= w && v <= w + 32'h1}, 32'h0000_0001);
    end
    $display("test prescale done");
    wr(`RTCS_A_CTRL, 32'h0000_0002);
    wr(`RTCS_A_FLX_TRIM, 32'h0000_8001);
    wr(`RTCS_A_FLX_CNT, 32'h0000_0000);
    edges(16);
    rd(`RTCS_A_FLX_CNT, v);
    chk({31'h0, !v[0] && v >= 32'h0000_001E && v <= 32'h0000_0022}, 32'h1);
    wr(`RTCS_A_FLX_TRIM, 32'h0000_800F);
    rd(`RTCS_A_FLX_CNT, v);
    edges(8);
    rd(`RTCS_A_FLX_CNT, w);
    chk(w, v);
    wr(`RTCS_A_FLX_TRIM, 32'h0000_0000);
    $display("test trim done");
    wr(`RTCS_A_IRQ_EN, 32'h0000_0006);
    wr(`RTCS_A_FLX_CNT, 32'h0000_0000);
    wr(`RTCS_A_FLX_ALARM, 32'h0000_0028);
    wr(`RTCS_A_FLX_AFRAC, 32'h0000_0000);
    wr(`RTCS_A_IRQ_CLR, 32'h0000_001F);
    edges(30);
    rd(`RTCS_A_STAT, v);
    chk({30'h0, v[2:1]}, 32'h0000_0000);
    edges(15);
    rd(`RTCS_A_STAT, v);
    chk({30'h0, v[2:1]}, 32'h0000_0001);
    edges(20);
    rd(`RTCS_A_STAT, v);
    chk({30'h0, v[2:1]}, 32'h0000_0003);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`RTCS_A_IRQ_CLR, 32'h0000_0006);
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0000_0000);
    $display("test alarms done");
    wr(`RTCS_A_IRQ_EN, 32'h0000_0018);
    wr(`RTCS_A_STB_PER, 32'h0000_0000);
    wr(`RTCS_A_STB_TGT, 32'h0000_0003);
    wr(`RTCS_A_CTRL, 32'h0000_0342);
    wr(`RTCS_A_FLX_CNT, 32'h0000_0000);
    wr(`RTCS_A_IRQ_CLR, 32'h0000_001F);
    k = 0;
    while (wake !== 1'b1 && k < 1000) begin
      @(posedge sys_clk);
      k++;
    end
    chk({31'h0, wake}, 32'h0000_0001);
    rd(`RTCS_A_CAP_CNT, v);
    chk(v, 32'h0000_0003);
    rd(`RTCS_A_CAP_FRAC, v);
    chk({31'h0, v >= 32'h1 && v <= 32'h3}, 32'h0000_0001);
    rd(`RTCS_A_STAT, v);
    chk({30'h0, v[4:3]}, 32'h0000_0003);
    wr(`RTCS_A_IRQ_EN, 32'h0000_0000);
    @(posedge sys_clk);
    chk({30'h0, irq, wake}, 32'h0000_0000);
    // Falling-edge capture: second pulse makes the sensor line drop
    wr(`RTCS_A_CTRL, 32'h0000_0742);
    wr(`RTCS_A_FLX_CNT, 32'h0000_0000);
    wr(`RTCS_A_IRQ_CLR, 32'h0000_001F);
    wr(`RTCS_A_IRQ_EN, 32'h0000_0010);
    repeat (600) @(posedge sys_clk);
    chk({31'h0, wake}, 32'h0000_0001);
    $display("test strobe done");
    wr(`RTCS_A_IRQ_EN, 32'h0000_0001);
    wr(`RTCS_A_CTRL, 32'h0000_0001);
    wr(`RTCS_A_FIX_CNT, 32'h0000_0007);
    wr(`RTCS_A_IRQ_CLR, 32'h0000_001F);
    wr(`RTCS_A_FIX_ALARM, 32'h0000_0007);
    repeat (3) @(posedge sys_clk);
    chk({30'h0, irq, wake}, 32'h0000_0003);
    $display("test fixed alarm done");
    // Crystal halted: only the RC source may count
    xtal_run <= 1'b0;
    wr(`RTCS_A_CTRL, 32'h0000_0006);
    wr(`RTCS_A_FLX_CNT, 32'h0000_0000);
    repeat (64) @(posedge sys_clk);
    rd(`RTCS_A_FLX_CNT, v);
    chk({31'h0, v >= 32'h0000_000F && v <= 32'h0000_0012}, 32'h1);
    wr(`RTCS_A_CTRL, 32'h0000_0002);
    rd(`RTCS_A_FLX_CNT, v);
    repeat (40) @(posedge sys_clk);
    rd(`RTCS_A_FLX_CNT, w);
    chk(w, v);
    $display("test source done");
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk({26'h0, irq, wake, pulse, fast_en, rc_en, xtal_en}, 32'h0000_0007);
    rd(`RTCS_A_CTRL, v);
    chk(v, 32'h0000_0000);
    $display("test reset done");
    summarize();
  end
  // Hang guard, well past the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
endmodule
bind rtcs_top rtcs_properties #(.CW(CW)) props_u (.sys_clk(sys_clk), .rst_n(rst_n),
  .ce(ce), .bus(bus), .rdata(rdata), .slow_crystal_oscillator_in(slow_crystal_oscillator_in),
  .slow_rc_oscillator_in(slow_rc_oscillator_in), .buck_active(buck_active),
  .fast_rc_oscillator_en(fast_rc_oscillator_en), .slow_rc_oscillator_en(slow_rc_oscillator_en),
  .slow_crystal_oscillator_en(slow_crystal_oscillator_en), .capture_event_in(capture_event_in),
  .sensor_trigger_pulse(sensor_trigger_pulse), .irq(irq), .wake(wake));
`default_nettype wire
